// file: acst_defines.svh
// constants for the converter sleep and auto-trigger control block
// assumes one 125 MHz clock and a 32-bit AHB-Lite register bus
`ifndef ACST_DEFINES_SVH
`define ACST_DEFINES_SVH

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define ACST_OFS_CTRL    8'h00
`define ACST_OFS_TRIG    8'h04
`define ACST_OFS_STATUS  8'h08
`define ACST_OFS_MASK    8'h0C
`define ACST_OFS_RESULT  8'h10
`define ACST_CTRL_PWR    0
`define ACST_CTRL_GO     1
`define ACST_CTRL_CLK    4:2
`define ACST_TRIG_SEL    4:0
`define ACST_STAT_DONE   0
`define ACST_STAT_BUSY   1
`define ACST_STAT_PWR    2
`define ACST_MASK_DONE   0

// ----------------------------------------
// conversion timing
// ----------------------------------------
`define ACST_RES_W       10
`define ACST_TAD_FIRST   4'h1
`define ACST_TAD_MSB     4'hA
`define ACST_TAD_LAST    4'hB
`define ACST_TAD_TWO     4'h2
`define ACST_INSN_CLKS   3'h4
`define ACST_CLK_RC_LO   2'h3
`define ACST_DIV_2       6'h01
`define ACST_DIV_4       6'h03
`define ACST_DIV_8       6'h07
`define ACST_DIV_16      6'h0F
`define ACST_DIV_32      6'h1F
`define ACST_DIV_64      6'h3F
`define ACST_DIV_RC      6'h1F
`define ACST_NUM_TRIG    17
`define ACST_HSIZE_WORD  3'h2
`define ACST_RESP_OKAY   1'b0

`endif

// file: acst_pkg.sv
// types shared by the converter control and its approximation engine
// assumes acst_defines.svh is on the include path
`default_nettype none
`include "acst_defines.svh"
package acst_pkg;
  typedef enum logic {acst_sar_idle, acst_sar_conv} acst_phase_t;

  typedef struct packed {
    acst_phase_t             phase;
    logic [3:0]              conversion_clock_period;
    logic [`ACST_RES_W-1:0]  trial;
    logic [`ACST_RES_W-1:0]  hold;
    logic [`ACST_RES_W-1:0]  result;
    logic                    done;
  } acst_sar_st_t;

  typedef struct packed {
    logic        power_on;
    logic        go;
    logic        pend;
    logic [2:0]  dly;
    logic [2:0]  clk_sel;
    logic [4:0]  trig_sel;
    logic        irq_en;
    logic        done_flag;
    logic        sleep_off;
    logic [5:0]  pre;
    logic        trig_prev;
    logic        ap_wr;
    logic        ap_rd;
    logic [7:0]  ap_addr;
    logic [31:0] hrdata;
    logic        hready;
    logic        irq;
    logic        wake;
    logic        analog_on;
  } acst_ctl_st_t;
endpackage
`default_nettype wire

// file: acst_sar.sv
// successive approximation engine with sample and hold
// assumes tick_in pulses once per conversion clock period
`default_nettype none
`include "acst_defines.svh"
module acst_sar (
  // clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   sys_rst_in,
  // control
  input  wire logic                   tick_in,
  input  wire logic                   start_in,
  input  wire logic                   term_in,
  input  wire logic                   kill_in,
  input  wire logic                   track_in,
  input  wire logic [`ACST_RES_W-1:0] sample_in,
  // results
  output logic                        busy_out,
  output logic                        done_out,
  output logic [`ACST_RES_W-1:0]      result_out
);
  acst_pkg::acst_sar_st_t st;
  acst_pkg::acst_sar_st_t next_st;
  logic [3:0]             bit_idx;
  logic [`ACST_RES_W-1:0] cand;

  // partial result: bits not yet converted copy the last converted bit
  function automatic logic [`ACST_RES_W-1:0] fill(input logic [`ACST_RES_W-1:0] t,
                                                  input logic [3:0] conversion_clock_period);
    logic [`ACST_RES_W-1:0] r;
    logic [3:0]             last;
    r    = '0;
    last = `ACST_TAD_LAST - conversion_clock_period;
    if (conversion_clock_period >= `ACST_TAD_TWO)
    begin
      for (int i = 0; i < `ACST_RES_W; i++)
        r[i] = (4'(i) < last) ? t[last] : t[i];
    end
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st      = st;
    next_st.done = 1'b0;
    bit_idx      = `ACST_TAD_MSB - st.conversion_clock_period;
    cand         = st.trial;
    if (st.conversion_clock_period >= `ACST_TAD_FIRST && st.conversion_clock_period <= `ACST_TAD_MSB)
      cand[bit_idx] = 1'b1;
    // hold follows the input only while acquiring, cleared only by reset
    if (track_in && st.phase == acst_pkg::acst_sar_idle)
      next_st.hold = sample_in;
    case (st.phase)
      acst_pkg::acst_sar_idle:
        if (start_in)
        begin
          next_st.phase = acst_pkg::acst_sar_conv;
          next_st.conversion_clock_period   = '0;
          next_st.trial = '0;
        end
      acst_pkg::acst_sar_conv:
        if (kill_in)
          next_st.phase = acst_pkg::acst_sar_idle;
        else if (term_in)
        begin
          next_st.phase  = acst_pkg::acst_sar_idle;
          next_st.result = fill(st.trial, st.conversion_clock_period);
        end
        else if (tick_in)
        begin
          next_st.conversion_clock_period = st.conversion_clock_period + `ACST_TAD_FIRST;
          if (st.conversion_clock_period >= `ACST_TAD_FIRST && st.conversion_clock_period <= `ACST_TAD_MSB && cand <= st.hold)
            next_st.trial = cand;
          if (st.conversion_clock_period == `ACST_TAD_LAST)
          begin
            next_st.phase  = acst_pkg::acst_sar_idle;
            next_st.result = st.trial;
            next_st.done   = 1'b1;
          end
        end
      default:
        next_st.phase = acst_pkg::acst_sar_idle;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign busy_out   = (st.phase == acst_pkg::acst_sar_conv);
  assign done_out   = st.done;
  assign result_out = st.result;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_hold_kept;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    !(track_in && st.phase == acst_pkg::acst_sar_idle) |=> $stable(st.hold);
  endproperty
  a_hold_kept: assert property (p_hold_kept) else $error("hold changed");

  property p_twelve;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    st.done |-> $past(st.conversion_clock_period) == `ACST_TAD_LAST;
  endproperty
  a_twelve: assert property (p_twelve) else $error("conversion not twelve periods");
endmodule // acst_sar
`default_nettype wire

// file: acst_ctrl.sv
// converter control: sleep handling, auto-trigger, registers, interrupt
// assumes an AHB-Lite master on one clock and synchronous trigger inputs
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`default_nettype none
`include "acst_defines.svh"
module acst_ctrl (
  // clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      sys_rst_in,
  // ahb-lite slave
  input  wire logic                      hsel_in,
  input  wire logic [31:0]               haddr_in,
  input  wire logic [1:0]                htrans_in,
  input  wire logic                      hwrite_in,
  input  wire logic [2:0]                hsize_in,
  input  wire logic                      hready_in,
  input  wire logic [31:0]               hwdata_in,
  output logic      [31:0]               hrdata_out,
  output logic                           hreadyout_out,
  output logic                           hresp_out,
  // device state and trigger sources
  input  wire logic                      sleep_in,
  input  wire logic [`ACST_NUM_TRIG-1:0] trig_src_in,
  input  wire logic [`ACST_RES_W-1:0]    sample_in,
  // interrupt, wake and analog power
  output logic                           irq_out,
  output logic                           wake_out,
  output logic                           analog_on_out
);
  acst_pkg::acst_ctl_st_t st;
  acst_pkg::acst_ctl_st_t next_st;
  logic                   trig_lvl;
  logic                   trig_edge;
  logic                   trig_fire;
  logic                   powered;
  logic                   rc_sel;
  logic                   wr_ctrl;
  logic                   clr_done;
  logic                   go_sw_set;
  logic                   go_sw_clr;
  logic                   go_req;
  logic                   kill;
  logic                   sar_start;
  logic                   sar_term;
  logic                   tick;
  logic                   sar_busy;
  logic                   sar_done;
  logic [`ACST_RES_W-1:0] sar_result;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // rc clock is any select with the two low bits set
  function automatic logic is_rc(input logic [2:0] sel);
    return sel[1:0] == `ACST_CLK_RC_LO;
  endfunction

  // terminal count of the conversion clock prescaler
  function automatic logic [5:0] div_of(input logic [2:0] sel);
    logic [5:0] d;
    d = `ACST_DIV_RC;
    case (sel)
      3'h0:    d = `ACST_DIV_2;
      3'h4:    d = `ACST_DIV_4;
      3'h1:    d = `ACST_DIV_8;
      3'h5:    d = `ACST_DIV_16;
      3'h2:    d = `ACST_DIV_32;
      3'h6:    d = `ACST_DIV_64;
      default: d = `ACST_DIV_RC;
    endcase
    return d;
  endfunction

  // select 0 means no source, 1 to 17 pick a source
  function automatic logic trig_pick(input logic [4:0] sel,
                                     input logic [`ACST_NUM_TRIG-1:0] src);
    logic v;
    v = 1'b0;
    for (int i = 0; i < `ACST_NUM_TRIG; i++)
      if (sel == 5'(i + 1))
        v = src[i];
    return v;
  endfunction

  // ----------------------------------------
  // approximation engine
  // ----------------------------------------
  acst_sar u_sar (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tick),
    .start_in   (sar_start),
    .term_in    (sar_term),
    .kill_in    (kill),
    .track_in   (powered && !st.pend),
    .sample_in  (sample_in),
    .busy_out   (sar_busy),
    .done_out   (sar_done),
    .result_out (sar_result)
  );

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  always_comb
  begin
    rc_sel    = is_rc(st.clk_sel);
    powered   = st.power_on && !st.sleep_off;
    trig_lvl  = trig_pick(st.trig_sel, trig_src_in);
    trig_edge = trig_lvl && !st.trig_prev;
    // no trigger in sleep, none while a conversion is pending or running
    trig_fire = trig_edge && !sleep_in && !st.go && powered;
    wr_ctrl   = st.ap_wr && st.ap_addr == `ACST_OFS_CTRL;
    clr_done  = st.ap_wr && st.ap_addr == `ACST_OFS_STATUS && hwdata_in[`ACST_STAT_DONE];
    go_sw_set = wr_ctrl && hwdata_in[`ACST_CTRL_GO] && !st.go && powered;
    go_sw_clr = wr_ctrl && !hwdata_in[`ACST_CTRL_GO] && st.go;
    go_req    = go_sw_set || trig_fire;
    // non-rc clock cannot run in sleep; power off ends everything
    kill      = (sleep_in && !rc_sel) || !st.power_on;
    sar_start = st.pend && st.dly == '0 && !kill && !go_sw_clr;
    sar_term  = go_sw_clr && sar_busy;
    tick      = sar_busy && st.pre == div_of(st.clk_sel);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st           = st;
    next_st.trig_prev = trig_lvl;
    next_st.ap_wr     = 1'b0;
    next_st.ap_rd     = 1'b0;
    // go flag and start delay
    if (go_req)
    begin
      next_st.go   = 1'b1;
      next_st.pend = 1'b1;
      next_st.dly  = rc_sel ? `ACST_INSN_CLKS : 3'h0;
    end
    else if (st.pend && st.dly != '0)
      next_st.dly = st.dly - 3'h1;
    if (sar_start)
      next_st.pend = 1'b0;
    if (sar_done)
      next_st.go = 1'b0;
    if (go_sw_clr || kill)
    begin
      next_st.go   = 1'b0;
      next_st.pend = 1'b0;
    end
    // conversion clock prescaler
    if (sar_start || tick)
      next_st.pre = '0;
    else if (sar_busy)
      next_st.pre = st.pre + 6'h01;
    // analog power-down in sleep, power bit untouched
    if (!sleep_in)
      next_st.sleep_off = 1'b0;
    else if (!rc_sel)
      next_st.sleep_off = 1'b1;
    else if (sar_done && !st.irq_en)
      next_st.sleep_off = 1'b1;
    next_st.wake = sar_done && sleep_in && st.irq_en;
    // sticky done flag, a new completion beats the clear
    next_st.done_flag = sar_done || (st.done_flag && !clr_done);
    // register writes in the data phase
    if (wr_ctrl)
    begin
      next_st.power_on = hwdata_in[`ACST_CTRL_PWR];
      next_st.clk_sel  = hwdata_in[`ACST_CTRL_CLK];
    end
    else if (st.ap_wr && st.ap_addr == `ACST_OFS_TRIG)
      next_st.trig_sel = hwdata_in[`ACST_TRIG_SEL];
    else if (st.ap_wr && st.ap_addr == `ACST_OFS_MASK)
      next_st.irq_en = hwdata_in[`ACST_MASK_DONE];
    // address phase capture, reads get one wait state
    if (hsel_in && htrans_in[1] && hready_in && hsize_in == `ACST_HSIZE_WORD)
    begin
      next_st.ap_wr   = hwrite_in;
      next_st.ap_rd   = !hwrite_in;
      next_st.ap_addr = haddr_in[7:0];
      next_st.hready  = hwrite_in;
    end
    // read data phase
    if (st.ap_rd)
    begin
      next_st.hready = 1'b1;
      next_st.hrdata = '0;
      if (st.ap_addr == `ACST_OFS_CTRL)
      begin
        next_st.hrdata[`ACST_CTRL_PWR] = st.power_on;
        next_st.hrdata[`ACST_CTRL_GO]  = st.go;
        next_st.hrdata[`ACST_CTRL_CLK] = st.clk_sel;
      end
      else if (st.ap_addr == `ACST_OFS_TRIG)
        next_st.hrdata[`ACST_TRIG_SEL] = st.trig_sel;
      else if (st.ap_addr == `ACST_OFS_STATUS)
      begin
        next_st.hrdata[`ACST_STAT_DONE] = st.done_flag;
        next_st.hrdata[`ACST_STAT_BUSY] = sar_busy;
        next_st.hrdata[`ACST_STAT_PWR]  = powered;
      end
      else if (st.ap_addr == `ACST_OFS_MASK)
        next_st.hrdata[`ACST_MASK_DONE] = st.irq_en;
      else if (st.ap_addr == `ACST_OFS_RESULT)
        next_st.hrdata[`ACST_RES_W-1:0] = sar_result;
    end
    // registered outputs
    next_st.irq       = next_st.done_flag && next_st.irq_en;
    next_st.analog_on = next_st.power_on && !next_st.sleep_off;
  end

  // state register
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      st        <= '0;
      st.hready <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata_out    = st.hrdata;
  assign hreadyout_out = st.hready;
  assign hresp_out     = `ACST_RESP_OKAY;
  assign irq_out       = st.irq;
  assign wake_out      = st.wake;
  assign analog_on_out = st.analog_on;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_sleep_stop;
    sleep_in && !is_rc(st.clk_sel) |=> !sar_busy;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("converted in sleep");

  property p_rc_delay;
    go_req && is_rc(st.clk_sel) && !sleep_in |=> !sar_start [*4];
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");

  property p_wake;
    sar_done && sleep_in && st.irq_en |=> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on done");

  property p_done_off;
    sar_done && sleep_in && !st.irq_en && st.power_on && !wr_ctrl |=>
      !analog_on_out && st.power_on;
  endproperty
  a_done_off: assert property (p_done_off) else $error("not powered down");

  property p_abort;
    sleep_in && !is_rc(st.clk_sel) && sar_busy && st.power_on && !wr_ctrl |=>
      !sar_busy && !analog_on_out && st.power_on;
  endproperty
  a_abort: assert property (p_abort) else $error("sleep did not abort");

  property p_trig;
    trig_fire |=> st.go && st.pend;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not set go");

  property p_trig_sleep;
    sleep_in && !st.go && !wr_ctrl |=> !st.go;
  endproperty
  a_trig_sleep: assert property (p_trig_sleep) else $error("trigger in sleep");

  property p_trig_busy;
    sar_busy && !go_sw_clr && !kill && !sar_done |=> !st.pend;
  endproperty
  a_trig_busy: assert property (p_trig_busy) else $error("trigger queued");

  property p_complete;
    sar_done |=> st.done_flag && !st.go;
  endproperty
  a_complete: assert property (p_complete) else $error("completion not flagged");

  property p_sticky;
    st.done_flag && !clr_done |=> st.done_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag lost");

  // ----------------------------------------
  // sleep, power, start delay, termination and interrupt checks
  // ----------------------------------------
  property p_prompt;
    go_req && !rc_sel |=> sar_start || kill || go_sw_clr;
  endproperty
  a_prompt: assert property (p_prompt) else $error("start delayed without rc clock");

  property p_wake_pulse;
    wake_out |=> !wake_out;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");

  property p_wake_aon;
    !sleep_in && st.power_on && !wr_ctrl |=> analog_on_out;
  endproperty
  a_wake_aon: assert property (p_wake_aon) else $error("analog not back after sleep");

  property p_kill;
    !st.power_on |=> !sar_busy && !st.go;
  endproperty
  a_kill: assert property (p_kill) else $error("converted while powered off");

  property p_sleep_aon;
    sleep_in && !rc_sel |=> !analog_on_out;
  endproperty
  a_sleep_aon: assert property (p_sleep_aon) else $error("analog left on in sleep");

  property p_term;
    sar_term |=> !sar_busy && !st.go && !sar_done;
  endproperty
  a_term: assert property (p_term) else $error("termination not clean");

  property p_go_idle;
    !st.go |-> !sar_busy;
  endproperty
  a_go_idle: assert property (p_go_idle) else $error("busy with go clear");

  property p_irq_done;
    sar_done && st.irq_en && !st.ap_wr |=> irq_out;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("no interrupt on done");
endmodule // acst_ctrl
`default_nettype wire

// file: acst_src_model.sv
// trigger source and analog level model for the converter control bench
// assumes the bench commands each trigger pulse through fire_in
`default_nettype none
module acst_src_model (
  // clock
  input  wire logic        ref_clk_in,
  // commands from the bench
  input  wire logic        fire_in,
  input  wire logic [4:0]  fire_sel_in,
  input  wire logic [9:0]  level_in,
  // towards the block
  output logic      [16:0] trig_src_out,
  output logic      [9:0]  sample_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_cnt = 2'h0;
  // raise the chosen source for a few cycles, low between pulses
  always_ff @(posedge ref_clk_in)
  begin
    if (fire_in)
    begin
      hold_cnt     <= 2'h3;
      trig_src_out <= 17'h00001 << (fire_sel_in - 5'h01);
    end
    else if (hold_cnt != 2'h0)
      hold_cnt <= hold_cnt - 2'h1;
    else
      trig_src_out <= 17'h00000;
  end
  // analog level follows the bench
  assign sample_out = level_in;
endmodule // acst_src_model
`default_nettype wire

// file: acst_ctrl_tb_top.sv
// self-checking bench for the converter sleep and auto-trigger control
// assumes acst_ctrl and acst_src_model are compiled beforehand
`default_nettype none
`include "acst_defines.svh"
module acst_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hready, hresp, sleep, irq, wake, aon, fire;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [16:0] trig;
  logic [9:0]  smp, level, lv;
  logic [4:0]  fire_sel;
  int          fail_count = 0;
  int          n_tests = 0;
  int          n;

  acst_ctrl uut (.ref_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .sleep_in(sleep), .trig_src_in(trig), .sample_in(smp), .irq_out(irq),
    .wake_out(wake), .analog_on_out(aon));
  acst_src_model src (.ref_clk_in(clk), .fire_in(fire), .fire_sel_in(fire_sel),
    .level_in(level), .trig_src_out(trig), .sample_out(smp));

  // ----------------------------------------
  // bus, compare and expectation helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    chk(rv & m, e);
  endtask

  task automatic wait_n(input int c);
    repeat (c) @(posedge clk);
  endtask

  // control word: power on, clock code, go
  function automatic logic [31:0] ctl(input logic [2:0] c, input logic g);
    return {27'h0000000, c, g, 1'b1};
  endfunction

  // cycles from go to completion: twelve periods, rc adds one instruction
  function automatic int conv_lo(input logic [2:0] c);
    if (c[1:0] == 2'h3)
      return 12 * 32 + 4;
    return 12 * (2 << {c[1:0], c[2]});
  endfunction

  // start a conversion once acquisition time has passed
  task automatic start(input logic [2:0] c);
    xfer(1'b1, `ACST_OFS_CTRL, ctl(c, 1'b0));
    wait_n(16);
    xfer(1'b1, `ACST_OFS_STATUS, 32'h00000001);
    xfer(1'b1, `ACST_OFS_CTRL, ctl(c, 1'b1));
  endtask

  task automatic pulse(input logic [4:0] s);
    fire_sel <= s;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog
  initial
  begin
    wait_n(20000);
    fail_count++;
    wrap_up;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {rst, hsel, hwrite, sleep, fire} = 5'b10000;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = `ACST_HSIZE_WORD;
    fire_sel = 5'h00;
    level = 10'h000;
    void'($urandom(32'h6c4d9ddd));
    wait_n(2);
    rst <= 1'b0;
    @(posedge clk);
    chk({28'h0, hresp, irq, wake, aon}, 32'h0);
    rd_chk(`ACST_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk(`ACST_OFS_STATUS, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h14, 32'hFFFFFFFF, 32'h0);
    // every clock code, timed by the interrupt; level moves mid-conversion
    xfer(1'b1, `ACST_OFS_MASK, 32'h00000001);
    rd_chk(`ACST_OFS_MASK, 32'h00000001, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      lv = 10'($urandom);
      level <= lv;
      start(3'(k));
      wait_n(2);
      level <= ~lv;
      n = 2;
      while (irq !== 1'b1 && n < 2000)
      begin
        @(posedge clk);
        n++;
      end
      chk(32'(n >= conv_lo(3'(k)) && n <= conv_lo(3'(k)) + 6), 32'h1);
      rd_chk(`ACST_OFS_RESULT, 32'h000003FF, {22'h0, lv});
      rd_chk(`ACST_OFS_CTRL, 32'h00000002, 32'h0);
      xfer(1'b1, `ACST_OFS_STATUS, 32'h00000001);
      wait_n(2);
      chk({31'h0, irq}, 32'h0);
    end
    // every trigger source; a second edge while busy is ignored
    xfer(1'b1, `ACST_OFS_MASK, 32'h00000000);
    xfer(1'b1, `ACST_OFS_CTRL, ctl(3'h0, 1'b0));
    for (int s = 1; s <= `ACST_NUM_TRIG; s++)
    begin
      lv = 10'($urandom);
      level <= lv;
      xfer(1'b1, `ACST_OFS_TRIG, 32'(s));
      rd_chk(`ACST_OFS_TRIG, 32'h0000001F, 32'(s));
      xfer(1'b1, `ACST_OFS_STATUS, 32'h00000001);
      wait_n(16);
      pulse(5'(s));
      wait_n(8);
      pulse(5'(s));
      wait_n(40);
      rd_chk(`ACST_OFS_STATUS, 32'h00000007, 32'h5);
      chk({31'h0, irq}, 32'h0);
      rd_chk(`ACST_OFS_RESULT, 32'h000003FF, {22'h0, lv});
    end
    // a byte-sized write is ignored, so the done flag survives
    hsize <= 3'h0;
    xfer(1'b1, `ACST_OFS_STATUS, 32'h00000001);
    hsize <= `ACST_HSIZE_WORD;
    rd_chk(`ACST_OFS_STATUS, 32'h00000001, 32'h1);
    // no auto-trigger asleep, on the rc clock so only sleep blocks it
    xfer(1'b1, `ACST_OFS_CTRL, ctl(3'h3, 1'b0));
    sleep <= 1'b1;
    xfer(1'b1, `ACST_OFS_STATUS, 32'h00000001);
    pulse(5'(`ACST_NUM_TRIG));
    wait_n(40);
    rd_chk(`ACST_OFS_STATUS, 32'h00000003, 32'h0);
    sleep <= 1'b0;
    // sleep on a system-derived clock aborts the conversion
    start(3'h6);
    wait_n(100);
    sleep <= 1'b1;
    wait_n(4);
    chk({31'h0, aon}, 32'h0);
    rd_chk(`ACST_OFS_CTRL, 32'h00000001, 32'h1);
    wait_n(900);
    rd_chk(`ACST_OFS_STATUS, 32'h00000003, 32'h0);
    sleep <= 1'b0;
    wait_n(2);
    chk({31'h0, aon}, 32'h1);
    // clearing go mid-way leaves a partial result and no done flag
    level <= 10'h3FF;
    start(3'h6);
    wait_n(300);
    xfer(1'b1, `ACST_OFS_CTRL, ctl(3'h6, 1'b0));
    wait_n(4);
    rd_chk(`ACST_OFS_RESULT, 32'h000003FF, 32'h3FF);
    rd_chk(`ACST_OFS_STATUS, 32'h00000007, 32'h4);
    // rc clock through sleep, with and without the interrupt
    for (int m = 0; m < 2; m++)
    begin
      lv = 10'($urandom);
      level <= lv;
      xfer(1'b1, `ACST_OFS_MASK, 32'(m));
      start(3'h3);
      sleep <= 1'b1;
      n = 0;
      repeat (500)
      begin
        @(posedge clk);
        if (wake === 1'b1)
          n = 1;
      end
      chk(32'(n), 32'(m));
      if (m == 0)
        chk({31'h0, aon}, 32'h0);
      rd_chk(`ACST_OFS_CTRL, 32'h00000003, 32'h1);
      sleep <= 1'b0;
      rd_chk(`ACST_OFS_RESULT, 32'h000003FF, {22'h0, lv});
      rd_chk(`ACST_OFS_STATUS, 32'h00000001, 32'h1);
      chk({31'h0, irq}, 32'(m));
    end
    wrap_up;
  end
endmodule // acst_ctrl_tb_top
`default_nettype wire
